/* common/imxreg_pkg.sv */
package imxreg_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_SYNC_LATCHED  = 8'h1A;
	localparam logic [7:0] IDX_SKEW_MEASURE  = 8'h1B;
	localparam logic [7:0] IDX_SKEW_IRQ_EN   = 8'h1C;
	localparam logic [7:0] IDX_SKEW_LATCHED  = 8'h1D;
	localparam logic [7:0] IDX_FLOSS_IRQ_EN  = 8'h1E;
	localparam logic [7:0] IDX_FLOSS_LATCHED = 8'h1F;
	localparam logic [7:0] IDX_SELFTEST_GO   = 8'h20;
	localparam logic [7:0] IDX_SELFTEST_RES  = 8'h21;
	localparam logic [7:0] IDX_LINE_CONTROL  = 8'h38;
	localparam logic [7:0] IDX_SYNC_IRQ_EN   = 8'h39;
	localparam int         BIT_TX_SEND       = 4;
	localparam int         BIT_ST_DONE       = 1;
	localparam int         BIT_ST_FAIL       = 0;
	localparam logic [7:0] RST_BYTE          = 8'h00;
	// Skew threshold in microseconds and the 8-bit step: 64 ms over 256 codes
	localparam int         SKEW_LIMIT_US     = 7750;
	localparam int         SKEW_RANGE_US     = 64000;
	localparam logic [7:0] SKEW_LIMIT_CODE   = 8'((SKEW_LIMIT_US * 256) / SKEW_RANGE_US);
	localparam int         CLK_MHZ           = 25;
endpackage

/* hdl/imxreg_latch.sv */
`timescale 1ns/100ps
`default_nettype none
module imxreg_latch #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// Events and software clear
	input  wire logic [W-1:0] setEv,
	input  wire logic [W-1:0] clrMask,
	// Sticky state
	output logic      [W-1:0] flags
);
	logic [W-1:0] flags_nxt;
	// Set wins over a clear in the same cycle
	assign flags_nxt = (flags & ~clrMask) | setEv;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) flags <= '0;
		else flags <= flags_nxt;
	end
endmodule
`default_nettype wire

/* hdl/imxreg_top.sv */
`timescale 1ns/100ps
`default_nettype none
module imxreg_top #(
	parameter int LINKS = 4
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	// APB slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic                  pready,
	output logic      [31:0]      prdata,
	output logic                  pslverr,
	// Line-bonding status from the framing logic
	input  wire logic [LINKS-1:0] rxSyncLive,
	input  wire logic [LINKS-1:0] txSyncLive,
	input  wire logic [7:0]       skewMeasure,
	input  wire logic             skewOverflow,
	input  wire logic [LINKS-1:0] farFrameLoss,
	input  wire logic [LINKS-1:0] nearFrameLoss,
	// Memory self-test engine
	input  wire logic             selftestComplete,
	input  wire logic             selftestBad,
	output logic                  selftestRun,
	// Traffic control and interrupt
	output logic                  txSendEnable,
	output logic                  trafficEnable,
	output logic                  irqReq
);
	logic [7:0] skewIrqEn_r;
	logic [7:0] flossIrqEn_r;
	logic [7:0] stGo_r;
	logic [7:0] lineCtl_r;
	logic [7:0] syncIrqEn_r;
	logic [7:0] skew_r;
	logic       stDone_r;
	logic       stFail_r;
	logic       irq_nxt;
	logic [7:0] syncFlags;
	logic [7:0] skewFlags;
	logic [7:0] flossFlags;
	logic [7:0] rdMux;

	wire        access  = psel && penable;
	wire        wrEn    = access && pwrite;
	wire        rdEn    = access && !pwrite;
	wire        aligned = (paddr[1:0] == 2'b00);
	wire [7:0]  idx     = {2'b00, paddr[7:2]} | {paddr[11:8] != 4'h0, 7'h00};

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		return aligned && (a == b);
	endfunction

	wire        wSkewEn  = wrEn && hit(idx, imxreg_pkg::IDX_SKEW_IRQ_EN);
	wire        wFlossEn = wrEn && hit(idx, imxreg_pkg::IDX_FLOSS_IRQ_EN);
	wire        wStGo    = wrEn && hit(idx, imxreg_pkg::IDX_SELFTEST_GO);
	wire        wLine    = wrEn && hit(idx, imxreg_pkg::IDX_LINE_CONTROL);
	wire        wSyncEn  = wrEn && hit(idx, imxreg_pkg::IDX_SYNC_IRQ_EN);
	// Latched registers clear by writing ones
	wire        wSyncLs  = wrEn && hit(idx, imxreg_pkg::IDX_SYNC_LATCHED);
	wire        wSkewLs  = wrEn && hit(idx, imxreg_pkg::IDX_SKEW_LATCHED);
	wire        wFlossLs = wrEn && hit(idx, imxreg_pkg::IDX_FLOSS_LATCHED);

	wire        known = hit(idx, imxreg_pkg::IDX_SYNC_LATCHED)
		|| hit(idx, imxreg_pkg::IDX_SKEW_MEASURE)
		|| hit(idx, imxreg_pkg::IDX_SKEW_IRQ_EN)
		|| hit(idx, imxreg_pkg::IDX_SKEW_LATCHED)
		|| hit(idx, imxreg_pkg::IDX_FLOSS_IRQ_EN)
		|| hit(idx, imxreg_pkg::IDX_FLOSS_LATCHED)
		|| hit(idx, imxreg_pkg::IDX_SELFTEST_GO)
		|| hit(idx, imxreg_pkg::IDX_SELFTEST_RES)
		|| hit(idx, imxreg_pkg::IDX_LINE_CONTROL)
		|| hit(idx, imxreg_pkg::IDX_SYNC_IRQ_EN);

	// Skew saturates at full scale past the measurable span
	wire [7:0]  skewNow = skewOverflow ? 8'hFF : skewMeasure;
	wire        skewErr = skewOverflow || (skewNow > imxreg_pkg::SKEW_LIMIT_CODE);
	wire        stStart = wStGo && pwdata[0] && !stGo_r[0];

	imxreg_latch #(.W(8)) uSyncLatch (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.setEv   ({txSyncLive, rxSyncLive}),
		.clrMask (wSyncLs ? pwdata[7:0] : 8'h00),
		.flags   (syncFlags)
	);
	imxreg_latch #(.W(8)) uSkewLatch (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.setEv   ({7'h00, skewErr}),
		.clrMask (wSkewLs ? {7'h00, pwdata[0]} : 8'h00),
		.flags   (skewFlags)
	);
	imxreg_latch #(.W(8)) uFlossLatch (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.setEv   ({farFrameLoss, nearFrameLoss}),
		.clrMask (wFlossLs ? pwdata[7:0] : 8'h00),
		.flags   (flossFlags)
	);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			skewIrqEn_r  <= imxreg_pkg::RST_BYTE;
			flossIrqEn_r <= imxreg_pkg::RST_BYTE;
			stGo_r       <= imxreg_pkg::RST_BYTE;
			lineCtl_r    <= imxreg_pkg::RST_BYTE;
			syncIrqEn_r  <= imxreg_pkg::RST_BYTE;
		end else begin
			if (wSkewEn) skewIrqEn_r <= {7'h00, pwdata[0]};
			if (wFlossEn) flossIrqEn_r <= pwdata[7:0];
			if (wStGo) stGo_r <= {7'h00, pwdata[0]};
			if (wLine) lineCtl_r <= pwdata[7:0];
			if (wSyncEn) syncIrqEn_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) skew_r <= 8'h00;
		else skew_r <= skewNow;
	end

	// Fail clears only by reset; done also clears when a new self-test is started
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stDone_r <= 1'b0;
			stFail_r <= 1'b0;
		end else begin
			if (stStart) stDone_r <= 1'b0;
			if (stGo_r[0] && selftestComplete) begin
				stDone_r <= 1'b1;
				if (selftestBad) stFail_r <= 1'b1;
			end
		end
	end

	assign irq_nxt = (skewFlags[0] && skewIrqEn_r[0])
		|| |(flossFlags & flossIrqEn_r)
		|| |(syncFlags & syncIrqEn_r);

	always_comb begin
		rdMux = 8'h00;
		if (hit(idx, imxreg_pkg::IDX_SYNC_LATCHED)) rdMux = syncFlags;
		if (hit(idx, imxreg_pkg::IDX_SKEW_MEASURE)) rdMux = skew_r;
		if (hit(idx, imxreg_pkg::IDX_SKEW_IRQ_EN)) rdMux = skewIrqEn_r;
		if (hit(idx, imxreg_pkg::IDX_SKEW_LATCHED)) rdMux = skewFlags;
		if (hit(idx, imxreg_pkg::IDX_FLOSS_IRQ_EN)) rdMux = flossIrqEn_r;
		if (hit(idx, imxreg_pkg::IDX_FLOSS_LATCHED)) rdMux = flossFlags;
		if (hit(idx, imxreg_pkg::IDX_SELFTEST_GO)) rdMux = stGo_r;
		// Fail reads zero until done; a fail from an earlier run still shows once a later run is done
		if (hit(idx, imxreg_pkg::IDX_SELFTEST_RES)) rdMux = {6'h00, stDone_r, stFail_r && stDone_r};
		if (hit(idx, imxreg_pkg::IDX_LINE_CONTROL)) rdMux = lineCtl_r;
		if (hit(idx, imxreg_pkg::IDX_SYNC_IRQ_EN)) rdMux = syncIrqEn_r;
	end

	// Zero-wait APB: ready in the first access cycle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pready        <= 1'b0;
			prdata        <= 32'h0000_0000;
			pslverr       <= 1'b0;
			irqReq        <= 1'b0;
			selftestRun   <= 1'b0;
			txSendEnable  <= 1'b0;
			trafficEnable <= 1'b0;
		end else begin
			pready        <= psel && !penable;
			prdata        <= (psel && !penable && !pwrite) ? {24'h000000, rdMux} : 32'h0000_0000;
			pslverr       <= psel && !penable && !known;
			irqReq        <= irq_nxt;
			selftestRun   <= stGo_r[0];
			txSendEnable  <= lineCtl_r[imxreg_pkg::BIT_TX_SEND] && !stGo_r[0];
			trafficEnable <= !stGo_r[0];
		end
	end

	logic rdSeen;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) rdSeen <= 1'b0;
		else rdSeen <= rdEn;
	end

	sequence failSeen;
		stGo_r[0] && selftestComplete && selftestBad;
	endsequence
	sequence startReq;
		wStGo && pwdata[0];
	endsequence

	fail_sticky_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		failSeen |=> stFail_r [*8])
		else $error("fail bit dropped without reset");
	done_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		stGo_r[0] && selftestComplete |=> stDone_r)
		else $error("done bit not set on completion");
	traffic_halt_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		startReq ##1 stGo_r[0] |=> !trafficEnable && !txSendEnable)
		else $error("traffic not halted during self-test");
	skew_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		skewNow > imxreg_pkg::SKEW_LIMIT_CODE |=> skewFlags[0])
		else $error("skew error not latched");
	skew_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		skewFlags[0] && skewIrqEn_r[0] |=> irqReq)
		else $error("skew interrupt missing");
	floss_latch_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		|farFrameLoss |=> |flossFlags[7:4])
		else $error("far frame loss not latched");
	near_latch_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		|nearFrameLoss |=> |flossFlags[3:0])
		else $error("near frame loss not latched");
	irq_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!irq_nxt |=> !irqReq)
		else $error("interrupt without enabled flag");
	sync_latch_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rxSyncLive[0] |=> syncFlags[0])
		else $error("rx sync not latched");
	skew_report_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!skewOverflow |=> skew_r == $past(skewMeasure))
		else $error("skew value not reported");
	send_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!lineCtl_r[imxreg_pkg::BIT_TX_SEND] |=> !txSendEnable)
		else $error("send enabled while bit clear");
	apb_ready_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		psel && !penable |=> pready ##1 !pready)
		else $error("apb ready timing wrong");

	// Sequences for a passing self-test and for enabled far and near frame loss
	sequence passSeen;
		stGo_r[0] && selftestComplete && !selftestBad;
	endsequence
	sequence farLossEnabled;
		|(flossFlags[7:4] & flossIrqEn_r[7:4]);
	endsequence
	sequence nearLossEnabled;
		|(flossFlags[3:0] & flossIrqEn_r[3:0]);
	endsequence

	rd_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rdSeen |-> prdata == 32'h0000_0000)
		else $error("read data left standing");
	skew_sat_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		skewOverflow |=> skew_r == 8'hFF)
		else $error("skew value not saturated");
	skew_ovf_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		skewOverflow |=> skewFlags[0])
		else $error("overflow skew not flagged");
	far_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		farLossEnabled |=> irqReq)
		else $error("far frame loss interrupt missing");
	near_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		nearLossEnabled |=> irqReq)
		else $error("near frame loss interrupt missing");
	sync_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		|(syncFlags & syncIrqEn_r) |=> irqReq)
		else $error("sync interrupt missing");
	run_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		stGo_r[0] |=> selftestRun)
		else $error("self-test not running");
	run_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!stGo_r[0] |=> !selftestRun)
		else $error("self-test running unasked");
	pass_clean_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		passSeen ##0 !stFail_r |=> !stFail_r)
		else $error("fail bit set on pass");
	res_mask_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		hit(idx, imxreg_pkg::IDX_SELFTEST_RES) && !stDone_r |-> !rdMux[0])
		else $error("result shown before done");
	send_pass_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		lineCtl_r[imxreg_pkg::BIT_TX_SEND] && !stGo_r[0] |=> txSendEnable)
		else $error("send blocked while enabled");
	traffic_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!stGo_r[0] |=> trafficEnable)
		else $error("traffic held without self-test");
	sync_bits_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rxSyncLive[2:0] != 3'b000 |=> (syncFlags[2:0] & $past(rxSyncLive[2:0])) == $past(rxSyncLive[2:0]))
		else $error("rx sync bits not latched");
	tx_sync_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		|txSyncLive |=> |syncFlags[7:4])
		else $error("tx sync not latched");
	slverr_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		psel && !penable && !known |=> pslverr)
		else $error("unmapped access not refused");
	unmapped_rd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		psel && !penable && !known && !pwrite |=> prdata == 32'h0000_0000)
		else $error("unmapped read returned data");
	ready_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(psel && !penable) |=> !pready)
		else $error("ready outside access cycle");
	done_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		stStart |=> !stDone_r)
		else $error("done not cleared on start");
	done_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		stDone_r && !stStart |=> stDone_r)
		else $error("done bit dropped");
	skew_en_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wSkewEn |=> skewIrqEn_r == {7'h00, $past(pwdata[0])})
		else $error("skew enable write lost");
	floss_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wFlossLs && pwdata[0] && !nearFrameLoss[0] |=> !flossFlags[0])
		else $error("frame loss flag not cleared");
	skew_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!skewIrqEn_r[0] && flossFlags == 8'h00 && syncFlags == 8'h00 |=> !irqReq)
		else $error("skew interrupt while disabled");
endmodule
`default_nettype wire

/* tb/imxreg_st_model.sv */
`timescale 1ns/100ps
`default_nettype none
module imxreg_st_model #(
	parameter int DELAY = 12
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// Engine control and result
	input  wire logic selftestRun,
	input  wire logic failMode,
	output logic      selftestComplete,
	output logic      selftestBad
);
	int cnt;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt <= 0;
			selftestComplete <= 1'b0;
			selftestBad <= 1'b0;
		end else begin
			selftestComplete <= 1'b0;
			// Bad only counts beside complete, so it wanders otherwise
			selftestBad <= ~selftestBad;
			cnt <= !selftestRun ? 0 : (cnt < DELAY ? cnt + 1 : cnt);
			if (selftestRun && cnt == DELAY - 1) begin
				selftestComplete <= 1'b1;
				selftestBad <= failMode;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [3:0]  rxSyncLive = 4'h0;
	logic [3:0]  txSyncLive = 4'h0;
	logic [7:0]  skewMeasure = 8'h00;
	logic        skewOverflow = 1'b0;
	logic [3:0]  farFrameLoss = 4'h0;
	logic [3:0]  nearFrameLoss = 4'h0;
	logic        failMode = 1'b0;
	logic        selftestComplete;
	logic        selftestBad;
	logic        selftestRun;
	logic        txSendEnable;
	logic        trafficEnable;
	logic        irqReq;
	logic [7:0]  rdq;
	logic        rde;
	logic [7:0]  ids [6] = '{8'h1B, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21};
	int          err_count = 0;
	int          n_tests = 0;
	int          cycles = 0;

	imxreg_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .rxSyncLive(rxSyncLive), .txSyncLive(txSyncLive),
		.skewMeasure(skewMeasure), .skewOverflow(skewOverflow), .farFrameLoss(farFrameLoss),
		.nearFrameLoss(nearFrameLoss), .selftestComplete(selftestComplete),
		.selftestBad(selftestBad), .selftestRun(selftestRun), .txSendEnable(txSendEnable),
		.trafficEnable(trafficEnable), .irqReq(irqReq));
	imxreg_st_model st_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .selftestRun(selftestRun),
		.failMode(failMode), .selftestComplete(selftestComplete), .selftestBad(selftestBad));

	initial forever #20 ref_clk = ~ref_clk;

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Answer taken at the edge where pready is sampled high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		chk("pready", 8'h01, {7'h00, pready});
		rdq = prdata[7:0];
		rde = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string nm);
		apb(1'b0, idx, 8'h00);
		chk(nm, exp, rdq);
	endtask

	task automatic pin(input string nm, input logic exp, input int wait_n);
		repeat (wait_n) @(posedge ref_clk);
		@(negedge ref_clk);
		case (nm)
			"irqReq": chk(nm, {7'h00, exp}, {7'h00, irqReq});
			"txSendEnable": chk(nm, {7'h00, exp}, {7'h00, txSendEnable});
			"trafficEnable": chk(nm, {7'h00, exp}, {7'h00, trafficEnable});
			default: chk(nm, {7'h00, exp}, {7'h00, selftestRun});
		endcase
		@(posedge ref_clk);
	endtask

	task automatic do_reset();
		sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
	endtask

	initial begin
		do_reset();
		foreach (ids[i]) rd(ids[i], 8'h00, "reset value");
		apb(1'b0, 8'h01, 8'h00);
		chk("slverr", 8'h01, {7'h00, rde});
		chk("unmapped data", 8'h00, rdq);
		skewMeasure <= 8'h1F;
		rd(imxreg_pkg::IDX_SKEW_MEASURE, 8'h1F, "skew value");
		rd(imxreg_pkg::IDX_SKEW_LATCHED, 8'h00, "skew flag at limit");
		skewMeasure <= 8'h20;
		rd(imxreg_pkg::IDX_SKEW_LATCHED, 8'h01, "skew flag above limit");
		pin("irqReq", 1'b0, 1);
		apb(1'b1, imxreg_pkg::IDX_SKEW_IRQ_EN, 8'h01);
		pin("irqReq", 1'b1, 2);
		skewMeasure <= 8'h00;
		apb(1'b1, imxreg_pkg::IDX_SKEW_LATCHED, 8'h01);
		pin("irqReq", 1'b0, 2);
		skewOverflow <= 1'b1;
		@(posedge ref_clk);
		skewOverflow <= 1'b0;
		rd(imxreg_pkg::IDX_SKEW_LATCHED, 8'h01, "skew flag overflow");
		apb(1'b1, imxreg_pkg::IDX_SKEW_LATCHED, 8'h01);
		nearFrameLoss <= 4'h1;
		farFrameLoss <= 4'h8;
		@(posedge ref_clk);
		nearFrameLoss <= 4'h0;
		farFrameLoss <= 4'h0;
		rd(imxreg_pkg::IDX_FLOSS_LATCHED, 8'h81, "frame loss flags");
		apb(1'b1, imxreg_pkg::IDX_FLOSS_IRQ_EN, 8'h01);
		pin("irqReq", 1'b1, 2);
		apb(1'b1, imxreg_pkg::IDX_LINE_CONTROL, 8'h00);
		apb(1'b1, imxreg_pkg::IDX_FLOSS_LATCHED, 8'h01);
		pin("irqReq", 1'b0, 2);
		apb(1'b1, imxreg_pkg::IDX_FLOSS_IRQ_EN, 8'h80);
		pin("irqReq", 1'b1, 2);
		rxSyncLive <= 4'h5;
		@(posedge ref_clk);
		rxSyncLive <= 4'h0;
		apb(1'b0, imxreg_pkg::IDX_SYNC_LATCHED, 8'h00);
		chk("sync flags", 8'h05, rdq & 8'h07);
		apb(1'b1, imxreg_pkg::IDX_LINE_CONTROL, 8'h10);
		pin("txSendEnable", 1'b1, 2);
		failMode <= 1'b1;
		apb(1'b1, imxreg_pkg::IDX_SELFTEST_GO, 8'h01);
		rd(imxreg_pkg::IDX_SELFTEST_RES, 8'h00, "result before done");
		pin("selftestRun", 1'b1, 0);
		pin("trafficEnable", 1'b0, 0);
		pin("txSendEnable", 1'b0, 0);
		repeat (20) @(posedge ref_clk);
		rd(imxreg_pkg::IDX_SELFTEST_RES, 8'h03, "result fail");
		apb(1'b1, imxreg_pkg::IDX_SELFTEST_RES, 8'h00);
		apb(1'b1, imxreg_pkg::IDX_SELFTEST_GO, 8'h00);
		rd(imxreg_pkg::IDX_SELFTEST_RES, 8'h03, "sticky fail");
		do_reset();
		rd(imxreg_pkg::IDX_SELFTEST_RES, 8'h00, "result after reset");
		failMode <= 1'b0;
		apb(1'b1, imxreg_pkg::IDX_SELFTEST_GO, 8'h01);
		repeat (20) @(posedge ref_clk);
		rd(imxreg_pkg::IDX_SELFTEST_RES, 8'h02, "result pass");
		close_out();
	end
endmodule
`default_nettype wire
